// ---- verilog/adc_ctrl.v ----
`timescale 1ns/1ps
`include "adc_map.vh"
// What this block does
// - row address ten bits at row strobe fall, column nine at column fall.
// - after power-up wait 100 us, then eight refresh cycles before access.
// - init uses column-first refresh so the internal counter is primed.
// - refresh all 1024 rows within each 128 ms interval.
// - row strobe low at most 10000 ns single, 100000 ns in page burst.
// - output enable off before driving write data in late writes.
// - read keeps write enable high until column or row strobe rises.
// - random cycles at least 130 ns apart, row precharge 50 ns.
// - page columns no faster than 45 ns, column precharge 10 ns.
// - column-first refresh: column setup 10 ns, hold 10 ns.
// - counter test column precharge at least 50 ns.
module adc_ctrl #(
  parameter POWERUP_CYC = (`ADC_POWERUP_US * 1000 + `ADC_CLK_NS - 1) / `ADC_CLK_NS,
  parameter REF_GAP_CYC =
    (`ADC_REFRESH_MS * 1000000 / `ADC_REFRESH_ROWS) / `ADC_CLK_NS,
  parameter RAS_MAX_CYC = `ADC_RAS_MAX_NS / `ADC_CLK_NS,
  parameter RASC_MAX_CYC = `ADC_RASC_MAX_NS / `ADC_CLK_NS
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        srst,
  // User request
  input  wire        req_valid,
  input  wire [1:0]  req_cmd,
  input  wire [18:0] req_addr,
  input  wire [7:0]  req_wdata,
  input  wire        req_page,
  output reg         req_ready_q,
  output reg         rsp_valid_q,
  output reg  [7:0]  rsp_rdata_q,
  output reg         init_done_q,
  // Memory pins
  output reg  [9:0]  mem_addr_q,
  output reg         mem_row_strobe_n_q,
  output reg         mem_col_strobe_n_q,
  output reg         mem_write_n_q,
  output reg         mem_out_en_n_q,
  output reg  [7:0]  mem_dq_out_q,
  output reg         mem_dq_oe_q,
  input  wire [7:0]  mem_dq_in
);
  // Round-up cycle count from ns
  function [7:0] cyc;
    input integer ns;
    integer t;
    begin
      t   = (ns + `ADC_CLK_NS - 1) / `ADC_CLK_NS;
      cyc = (t > 0) ? t[7:0] : 8'h01;
    end
  endfunction

  localparam [7:0] C_RP   = cyc(`ADC_RP_MIN_NS);
  localparam [7:0] C_RCD  = cyc(`ADC_RCD_MIN_NS);
  localparam [7:0] C_RAS  = cyc(`ADC_RAS_MIN_NS);
  localparam [7:0] C_CAS  = cyc(`ADC_ACCESS_NS - `ADC_RCD_MIN_NS);
  localparam [7:0] C_CP   = cyc(`ADC_CP_MIN_NS);
  localparam [7:0] C_CSR  = cyc(`ADC_CSR_MIN_NS);
  localparam [7:0] C_CHR  = cyc(`ADC_CHR_MIN_NS);
  localparam [7:0] C_ODD  = cyc(`ADC_ODD_MIN_NS);
  localparam [7:0] C_WP   = cyc(`ADC_WCH_MIN_NS);
  localparam [7:0] C_RC   = cyc(`ADC_RC_MIN_NS);

  // Counter end points at counter width
  localparam [23:0] REF_LAST  = REF_GAP_CYC - 1;
  localparam [23:0] PWR_COUNT = POWERUP_CYC;
  localparam [3:0]  INIT_LAST = `ADC_INIT_CYCLES - 1;

  // States, one-hot
  localparam [9:0] S_PWR  = 10'h001;
  localparam [9:0] S_IDLE = 10'h002;
  localparam [9:0] S_RAS  = 10'h004;
  localparam [9:0] S_CAS  = 10'h008;
  localparam [9:0] S_OEOF = 10'h010;
  localparam [9:0] S_WLAT = 10'h020;
  localparam [9:0] S_CPRE = 10'h040;
  localparam [9:0] S_PRE  = 10'h080;
  localparam [9:0] S_RCS  = 10'h100;
  localparam [9:0] S_RCH  = 10'h200;

  reg [9:0]  state_q;
  reg [7:0]  wait_q;
  reg [3:0]  init_cnt_q;
  reg        pwr_load_q;
  reg [23:0] ref_cnt_q;
  reg        ref_due_q;
  reg [23:0] ras_cnt_q;
  reg [7:0]  cyc_cnt_q;
  reg [1:0]  cmd_q;
  reg [9:0]  row_q;
  reg [8:0]  col_q;
  reg        page_q;
  reg [7:0]  wdata_q;
  wire       same_row = req_valid && (req_addr[18:9] == row_q);
  wire       ras_limit = (ras_cnt_q >= (page_q ? RASC_MAX_CYC - 8 : RAS_MAX_CYC - 8));
  wire       refresh_cmd = ref_due_q || !init_done_q;
  wire       pwr_done;

  // one refresh per row slot of the interval
  always @(posedge mclk) begin
    if (srst) begin
      ref_cnt_q <= 24'h000000;
      ref_due_q <= 1'b0;
    end else begin
      if (ref_cnt_q >= REF_LAST) begin
        ref_cnt_q <= 24'h000000;
        ref_due_q <= 1'b1;
      end else begin
        ref_cnt_q <= ref_cnt_q + 24'h000001;
      end
      if (state_q == S_RCH && wait_q == 8'h00 && !(ref_cnt_q >= REF_LAST))
        ref_due_q <= 1'b0;
    end
  end

  always @(posedge mclk) begin
    if (srst || mem_row_strobe_n_q)
      ras_cnt_q <= 24'h000000;
    else
      ras_cnt_q <= ras_cnt_q + 24'h000001;
  end

  always @(posedge mclk) begin
    if (srst)
      cyc_cnt_q <= 8'hff;
    else if (state_q == S_RAS && wait_q == C_RCD)
      cyc_cnt_q <= 8'h00;
    else if (cyc_cnt_q != 8'hff)
      cyc_cnt_q <= cyc_cnt_q + 8'h01;
  end

  // Load the pause timer on the first edge after reset
  always @(posedge mclk) begin
    pwr_load_q <= srst;
  end

  adc_timer #(
    .W      (24)
  ) u_pwr_timer (
    .mclk   (mclk),
    .srst   (srst),
    .load   (pwr_load_q),
    .count  (PWR_COUNT),
    .done_q (pwr_done)
  );

  // Main sequencer
  always @(posedge mclk) begin
    if (srst) begin
      state_q            <= S_PWR;
      wait_q             <= 8'h00;
      init_cnt_q         <= 4'h0;
      col_q              <= 9'h000;
      init_done_q        <= 1'b0;
      req_ready_q        <= 1'b0;
      rsp_valid_q        <= 1'b0;
      rsp_rdata_q        <= 8'h00;
      mem_addr_q         <= 10'h000;
      mem_row_strobe_n_q <= 1'b1;
      mem_col_strobe_n_q <= 1'b1;
      mem_write_n_q      <= 1'b1;
      mem_out_en_n_q     <= 1'b1;
      mem_dq_out_q       <= 8'h00;
      mem_dq_oe_q        <= 1'b0;
      cmd_q              <= 2'h0;
      row_q              <= 10'h000;
      page_q             <= 1'b0;
      wdata_q            <= 8'h00;
    end else begin
      rsp_valid_q <= 1'b0;
      req_ready_q <= 1'b0;
      if (wait_q != 8'h00)
        wait_q <= wait_q - 8'h01;
      case (state_q)
        S_PWR: begin
          if (pwr_done)
            state_q <= S_IDLE;
        end
        S_IDLE: begin
          // init and periodic refresh are column-first
          if (refresh_cmd && wait_q == 8'h00) begin
            mem_col_strobe_n_q <= 1'b0;
            wait_q             <= C_CSR;
            state_q            <= S_RCS;
          end else if (req_valid && wait_q == 8'h00 && cyc_cnt_q >= C_RC - 8'h01) begin
            mem_addr_q         <= req_addr[18:9];
            row_q              <= req_addr[18:9];
            col_q              <= req_addr[8:0];
            cmd_q              <= req_cmd;
            wdata_q            <= req_wdata;
            page_q             <= req_page;
            req_ready_q        <= 1'b1;
            mem_row_strobe_n_q <= 1'b0;
            wait_q             <= C_RCD;
            state_q            <= S_RAS;
          end
        end
        S_RAS: begin
          if (wait_q == 8'h00) begin
            mem_addr_q <= {1'b0, col_q};
            state_q    <= S_CAS;
          end
        end
        S_CAS: begin
          // early write sets write enable on the same edge as column fall
          if (cmd_q == `ADC_CMD_WRITE) begin
            mem_write_n_q <= 1'b0;
            mem_dq_out_q  <= wdata_q;
            mem_dq_oe_q   <= 1'b1;
          end else begin
            // write enable stays high through a read
            mem_write_n_q  <= 1'b1;
            mem_out_en_n_q <= 1'b0;
          end
          mem_col_strobe_n_q <= 1'b0;
          wait_q             <= C_CAS;
          state_q            <= S_OEOF;
        end
        S_OEOF: begin
          if (wait_q == 8'h00) begin
            // sample after the longest access delay
            // data only trusted in read or modify cycles
            if (cmd_q != `ADC_CMD_WRITE) begin
              rsp_rdata_q <= mem_dq_in;
              rsp_valid_q <= 1'b1;
            end
            if (cmd_q == `ADC_CMD_RMW) begin
              // output enable off before driving data
              mem_out_en_n_q <= 1'b1;
              wait_q         <= C_ODD;
              state_q        <= S_WLAT;
            end else begin
              mem_col_strobe_n_q <= 1'b1;
              mem_write_n_q      <= 1'b1;
              mem_dq_oe_q        <= 1'b0;
              mem_out_en_n_q     <= 1'b1;
              wait_q             <= C_CP;
              state_q            <= S_CPRE;
            end
          end
        end
        S_WLAT: begin
          // late write enable after the read completes
          // data is taken on write enable fall
          if (wait_q == 8'h01) begin
            mem_dq_out_q <= wdata_q;
            mem_dq_oe_q  <= 1'b1;
          end else if (wait_q == 8'h00 && mem_write_n_q) begin
            mem_write_n_q <= 1'b0;
            wait_q        <= C_WP;
          end else if (wait_q == 8'h00) begin
            mem_col_strobe_n_q <= 1'b1;
            mem_write_n_q      <= 1'b1;
            mem_dq_oe_q        <= 1'b0;
            wait_q             <= C_CP;
            state_q            <= S_CPRE;
          end
        end
        S_CPRE: begin
          // page column precharge, then next column if same row
          // leave the page before the row strobe limit
          // later page columns are column-access timed
          if (wait_q == 8'h00) begin
            if (same_row && page_q && !ras_limit && !ref_due_q) begin
              mem_addr_q  <= {1'b0, req_addr[8:0]};
              cmd_q       <= req_cmd;
              wdata_q     <= req_wdata;
              page_q      <= req_page;
              req_ready_q <= 1'b1;
              state_q     <= S_CAS;
            end else begin
              mem_row_strobe_n_q <= 1'b1;
              wait_q             <= C_RP;
              state_q            <= S_PRE;
            end
          end
        end
        S_PRE: begin
          // row precharge before the next cycle
          if (wait_q == 8'h00)
            state_q <= S_IDLE;
        end
        S_RCS: begin
          if (wait_q == 8'h00) begin
            mem_row_strobe_n_q <= 1'b0;
            wait_q             <= C_RAS;
            state_q            <= S_RCH;
          end else if (wait_q == C_RAS - C_CHR) begin
            mem_col_strobe_n_q <= 1'b0;
          end
        end
        S_RCH: begin
          // column hold after row fall, released mid pulse
          // column stays high long enough between uses
          if (wait_q == C_RAS - C_CHR)
            mem_col_strobe_n_q <= 1'b1;
          if (wait_q == 8'h00) begin
            mem_row_strobe_n_q <= 1'b1;
            mem_col_strobe_n_q <= 1'b1;
            wait_q             <= C_RP > cyc(`ADC_CPT_MIN_NS) ? C_RP : cyc(`ADC_CPT_MIN_NS);
            state_q            <= S_PRE;
            if (!init_done_q) begin
              init_cnt_q <= init_cnt_q + 4'h1;
              if (init_cnt_q == INIT_LAST)
                init_done_q <= 1'b1;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- verilog/adc_map.vh ----
`ifndef ADC_MAP_VH
`define ADC_MAP_VH
// Clock period in ns
`define ADC_CLK_NS 10
// Power-up pause in us, and initialization refresh count
`define ADC_POWERUP_US 100
`define ADC_INIT_CYCLES 8
// Refresh interval in ms, rows per interval
`define ADC_REFRESH_MS 128
`define ADC_REFRESH_ROWS 1024
// Strobe limits in ns
`define ADC_RAS_MAX_NS 10000
`define ADC_RASC_MAX_NS 100000
`define ADC_RC_MIN_NS 130
`define ADC_RP_MIN_NS 50
`define ADC_RAS_MIN_NS 70
`define ADC_RCD_MIN_NS 20
`define ADC_CAS_MIN_NS 20
`define ADC_PC_MIN_NS 45
`define ADC_CP_MIN_NS 10
`define ADC_CPT_MIN_NS 50
`define ADC_CSR_MIN_NS 10
`define ADC_CHR_MIN_NS 10
`define ADC_ACCESS_NS 70
`define ADC_ODD_MIN_NS 20
`define ADC_WCH_MIN_NS 15
`define ADC_WP_MIN_NS 10
// Command codes
`define ADC_CMD_READ 2'h0
`define ADC_CMD_WRITE 2'h1
`define ADC_CMD_RMW 2'h2
`endif

// ---- verilog/adc_timer.v ----
`timescale 1ns/1ps
// Down counter: load a cycle count, done sets and holds when it expires
module adc_timer #(
  parameter W = 24
) (
  // Clock and reset
  input  wire         mclk,
  input  wire         srst,
  // Control
  input  wire         load,
  input  wire [W-1:0] count,
  // Status
  output reg          done_q
);
  reg [W-1:0] cnt_q;

  // Count down to one, then flag done
  always @(posedge mclk) begin
    if (srst) begin
      cnt_q  <= {W{1'b0}};
      done_q <= 1'b0;
    end else if (load) begin
      cnt_q  <= count;
      done_q <= 1'b0;
    end else if (cnt_q > {{(W-1){1'b0}}, 1'b1}) begin
      cnt_q  <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end else if (cnt_q == {{(W-1){1'b0}}, 1'b1}) begin
      cnt_q  <= {W{1'b0}};
      done_q <= 1'b1;
    end
  end
endmodule

// ---- testbench/adc_ctrl_chk.sv ----
`timescale 1ns/1ps
// Pin protocol checker for the memory controller
module adc_ctrl_chk #(
  parameter POWERUP_CYC  = 10000,
  parameter RASC_MAX_CYC = 10000
) (
  // Clock and reset
  input wire mclk,
  input wire srst,
  // User side status
  input wire req_ready_q,
  input wire init_done_q,
  // Memory strobes and data enable
  input wire mem_row_strobe_n_q,
  input wire mem_col_strobe_n_q,
  input wire mem_write_n_q,
  input wire mem_out_en_n_q,
  input wire mem_dq_oe_q
);
  wire       rn = mem_row_strobe_n_q;
  wire       cn = mem_col_strobe_n_q;
  wire       wn = mem_write_n_q;
  reg [23:0] up_q;
  reg [23:0] low_q;
  reg [7:0]  rgap_q;
  reg [7:0]  cgap_q;
  reg [3:0]  nref_q;
  reg        rn_q;
  reg        cn_q;
  // Time since reset, row low time, gaps between strobe falls, init refreshes
  always @(posedge mclk) begin
    rn_q   <= rn;
    cn_q   <= cn;
    up_q   <= srst ? 24'h0 : up_q + 24'h1;
    low_q  <= rn ? 24'h0 : low_q + 24'h1;
    rgap_q <= srst ? 8'hff : (rn_q && !rn) ? 8'h1 : (rgap_q == 8'hff ? rgap_q : rgap_q + 8'h1);
    cgap_q <= srst ? 8'hff : (cn_q && !cn) ? 8'h1 : (cgap_q == 8'hff ? cgap_q : cgap_q + 8'h1);
    if (srst) begin
      nref_q <= 4'h0;
    end else if (rn_q && !rn && !cn && nref_q != 4'hf) begin
      nref_q <= nref_q + 4'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  chk_ready_after_init: assert property (req_ready_q |-> init_done_q)
    else $error("request taken before init done");
  chk_init_wait_count: assert property ($rose(init_done_q) |->
    nref_q >= 4'h8 && up_q >= POWERUP_CYC) else $error("init too short");
  chk_init_col_first: assert property ($fell(rn) && !init_done_q |-> !cn)
    else $error("init cycle not column first");
  chk_row_low_max: assert property (!rn |-> low_q < RASC_MAX_CYC)
    else $error("row strobe low too long");
  chk_row_precharge: assert property ($rose(rn) |-> rn [*5])
    else $error("row precharge too short");
  chk_cycle_spacing: assert property ($fell(rn) |-> rgap_q >= 8'd13)
    else $error("row cycles too close");
  chk_page_spacing: assert property ($fell(cn) |-> cgap_q >= 8'd5)
    else $error("column cycles too close");
  chk_refresh_col_setup: assert property ($fell(rn) && !cn |-> !$past(cn))
    else $error("column setup before refresh short");
  chk_no_bus_fight: assert property (mem_dq_oe_q |-> mem_out_en_n_q)
    else $error("data driven while outputs on");
  chk_oe_to_data: assert property ($rose(mem_dq_oe_q) |-> $past(mem_out_en_n_q, 2))
    else $error("data driven too soon after output off");
  chk_late_write_delay: assert property ($fell(wn) && !cn && !$fell(cn) |->
    !$past(cn, 5) && !$past(rn, 10)) else $error("late write too early");
  cover property ($fell(rn) && !cn);
  cover property ($fell(wn) && !cn);
  cover property ($fell(cn) && !rn && cgap_q < 8'd13);
endmodule

bind adc_ctrl adc_ctrl_chk #(.POWERUP_CYC(POWERUP_CYC), .RASC_MAX_CYC(RASC_MAX_CYC)) u_chk (
  .mclk(mclk), .srst(srst), .req_ready_q(req_ready_q), .init_done_q(init_done_q),
  .mem_row_strobe_n_q(mem_row_strobe_n_q), .mem_col_strobe_n_q(mem_col_strobe_n_q),
  .mem_write_n_q(mem_write_n_q), .mem_out_en_n_q(mem_out_en_n_q),
  .mem_dq_oe_q(mem_dq_oe_q));

// ---- testbench/adc_mem_model.sv ----
`timescale 1ns/1ps
// Behavioural memory array facing the controller
module adc_mem_model (
  // Clock used to age the column strobe and hold the last shown value
  input  wire        mclk,
  // Memory pins
  input  wire [9:0]  addr,
  input  wire        row_n,
  input  wire        col_n,
  input  wire        we_n,
  input  wire        oe_n,
  input  wire [7:0]  din,
  input  wire        din_oe,
  output logic [7:0] dout,
  // Refresh count for the bench
  output int         ref_cnt
);
  logic [7:0] mem [0:524287];
  logic [9:0] row;
  logic [8:0] col;
  logic       early;
  logic [3:0] age;
  logic [7:0] last;
  wire  [7:0] bus = din_oe ? din : 8'hxx; // Undriven data stores as unknown
  initial begin
    ref_cnt = 0;
    early = 1'b0;
    age = 4'h0;
    last = 8'h00;
  end
  // latch row or count a column first refresh
  always @(negedge row_n) if (!col_n) ref_cnt++; else row = addr;
  // latch column, early write stores here
  always @(negedge col_n) if (!row_n) begin
    col = addr[8:0];
    early = !we_n;
    if (!we_n) mem[{row, col}] = bus;
  end
  // late write stores at write enable fall
  always @(negedge we_n) if (!row_n && !col_n) mem[{row, col}] = bus;
  // Column age and last shown value
  always @(posedge mclk) begin
    age <= col_n ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
    last <= dout;
  end
  // cell data a fixed delay after column fall, else toggling
  assign dout = (!row_n && !col_n && !oe_n && !early && age >= 4'h2) ?
                mem[{row, col}] : ~last;
endmodule

// ---- testbench/adc_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`include "adc_map.vh"
// Self-checking bench for the memory controller
module adc_ctrl_tb_top;
  localparam int PUP = 20;
  localparam int GAP = 300;
  logic       mclk = 1'b0;
  logic       srst = 1'b1;
  logic       req_valid = 1'b0;
  logic [1:0] req_cmd = 2'h0;
  logic [18:0] req_addr = 19'h0;
  logic [7:0] req_wdata = 8'h0;
  logic       req_page = 1'b0;
  wire        req_ready_q, rsp_valid_q, init_done_q;
  wire        row_n, col_n, we_n, oe_n, dq_oe;
  wire [7:0]  rsp_rdata_q, dq_out, dq_in;
  wire [9:0]  maddr;
  int         ref_cnt, bad_count, comparisons, cyc;
  logic [7:0] rd;
  adc_ctrl #(.POWERUP_CYC(PUP), .REF_GAP_CYC(GAP)) dut (
    .mclk(mclk), .srst(srst), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_page(req_page),
    .req_ready_q(req_ready_q), .rsp_valid_q(rsp_valid_q), .rsp_rdata_q(rsp_rdata_q),
    .init_done_q(init_done_q), .mem_addr_q(maddr), .mem_row_strobe_n_q(row_n),
    .mem_col_strobe_n_q(col_n), .mem_write_n_q(we_n), .mem_out_en_n_q(oe_n),
    .mem_dq_out_q(dq_out), .mem_dq_oe_q(dq_oe), .mem_dq_in(dq_in));
  adc_mem_model u_mem (
    .mclk(mclk), .addr(maddr), .row_n(row_n), .col_n(col_n), .we_n(we_n),
    .oe_n(oe_n), .din(dq_out), .din_oe(dq_oe), .dout(dq_in), .ref_cnt(ref_cnt));
  // Clock and hang limit
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      results;
    end
  end
  // Closing report
  task results;
    $display("Compares %0d, errors %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Compare one value
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One request, held until taken; returns read data or unknown
  task req(input logic [1:0] c, input logic [18:0] a, input logic [7:0] w,
           input logic pg);
    int n;
    @(negedge mclk);
    req_valid = 1'b1;
    req_cmd = c;
    req_addr = a;
    req_wdata = w;
    req_page = pg;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (req_ready_q !== 1'b1 && n < 2000);
    chk("request taken", 1, req_ready_q);
    chk("init done at accept", 1, init_done_q);
    req_valid = 1'b0;
    rd = 8'hxx;
    if (c != `ADC_CMD_WRITE) begin
      n = 0;
      while (rsp_valid_q !== 1'b1 && n < 100) begin
        @(negedge mclk);
        n++;
      end
      if (n < 100) rd = rsp_rdata_q;
    end
  endtask
  // Request made right after reset waits for init
  task t_init;
    req(`ADC_CMD_WRITE, {10'h3ff, 9'h1ff}, 8'ha5, 1'b0);
    chk("init refreshes", 1, ref_cnt >= 8);
  endtask
  // Boundary addresses, one write then back to back reads
  task t_rw;
    req(`ADC_CMD_WRITE, {10'h000, 9'h000}, 8'h5a, 1'b0);
    req(`ADC_CMD_READ, {10'h3ff, 9'h1ff}, 8'h00, 1'b0);
    chk("read high corner", 8'ha5, rd);
    req(`ADC_CMD_READ, {10'h000, 9'h000}, 8'h00, 1'b0);
    chk("read low corner", 8'h5a, rd);
  endtask
  // Read-modify-write returns old data and stores new
  task t_rmw;
    req(`ADC_CMD_RMW, {10'h3ff, 9'h1ff}, 8'h3c, 1'b0);
    chk("rmw old data", 8'ha5, rd);
    req(`ADC_CMD_READ, {10'h3ff, 9'h1ff}, 8'h00, 1'b0);
    chk("rmw new data", 8'h3c, rd);
  endtask
  // Page burst in one row, different columns
  task t_page;
    req(`ADC_CMD_WRITE, {10'h155, 9'h0aa}, 8'h11, 1'b1);
    req(`ADC_CMD_WRITE, {10'h155, 9'h155}, 8'h22, 1'b0);
    req(`ADC_CMD_READ, {10'h155, 9'h0aa}, 8'h00, 1'b1);
    chk("page read one", 8'h11, rd);
    req(`ADC_CMD_READ, {10'h155, 9'h155}, 8'h00, 1'b0);
    chk("page read two", 8'h22, rd);
  endtask
  // Idle period keeps refreshing
  task t_refresh;
    int r0;
    r0 = ref_cnt;
    repeat (3 * GAP) @(negedge mclk);
    chk("refreshes in idle", 1, ref_cnt - r0 >= 3 * GAP / GAP - 1);
  endtask
  // Main sequence
  initial begin
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    t_init;
    t_rw;
    t_rmw;
    t_page;
    t_refresh;
    results;
  end
endmodule
